//--- gpio_bit_cell.sv
// One port bit: mode decode from configuration and latch, plus input synchroniser
`timescale 1ns/100ps
module gpio_bit_cell (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control
  input wire logic cfg,
  input wire logic dat,
  // Pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic pin_pull,
  // Sampled level
  output logic sense
);
  logic meta_r;

  // Drive and pull decode per bit
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_oe <= 1'b0;
      pin_out <= 1'b0;
      pin_pull <= 1'b0;
    end else begin
      pin_oe <= cfg;
      pin_out <= cfg & dat;
      pin_pull <= ~cfg & dat;
    end
  end

  // Two-stage synchroniser, any mode
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_r <= 1'b0;
      sense <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sense <= meta_r;
    end
  end
endmodule

//--- gpio_board_model.sv
// Board loads on the port pins: drivers, pull-ups and floating lines
`timescale 1ns/100ps
module gpio_board_model (
  // Clock
  input wire logic mclk,
  // Device side
  input wire logic [55:0] pins_out,
  input wire logic [55:0] pins_oe,
  input wire logic [55:0] pins_pull,
  // Board side
  input wire logic [55:0] ext,
  input wire logic [55:0] ext_en,
  // Resolved levels
  output logic [55:0] pins_in
);
  logic [55:0] float_r = 56'h0;
  // Floating lines change every cycle
  always @(posedge mclk) begin
    float_r <= ~float_r;
  end
  // Board sources yield to the device driver
  assign pins_in = (pins_oe & pins_out) | (~pins_oe & ext_en & ext)
    | (~pins_oe & ~ext_en & (pins_pull | float_r));
endmodule

//--- gpio_pkg.sv
// Package with register map, field positions and pin carrier types for the port block
package gpio_pkg;
  localparam int NUM_PORTS = 7;
  localparam logic [2:0] PORT_A = 3'h0;
  localparam logic [2:0] PORT_B = 3'h1;
  localparam logic [2:0] PORT_C = 3'h2;
  localparam logic [2:0] PORT_E = 3'h3;
  localparam logic [2:0] PORT_F = 3'h4;
  localparam logic [2:0] PORT_G = 3'h5;
  localparam logic [2:0] PORT_L = 3'h6;
  localparam logic [7:0] PORT_F_MASK = 8'h0F;
  // Byte address = port*16 + register*4
  localparam logic [1:0] REG_CONFIG = 2'h0;
  localparam logic [1:0] REG_LATCH = 2'h1;
  localparam logic [1:0] REG_SENSE = 2'h2;
  localparam logic [1:0] REG_SPECIAL = 2'h3;
  localparam logic [7:0] ADDR_PORT_D = 8'h70;
  localparam logic [7:0] ADDR_STATUS = 8'h74;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] PORT_D_RESET = 8'hFF;
  localparam int G_HALT_BIT = 7;
  localparam int G_IDLE_BIT = 6;
  localparam int G_DELAY_BIT = 7;
  localparam int G_ALT_SK_BIT = 6;
  localparam int G_WATCHDOG_BIT = 1;
  localparam int G_INPUT_ONLY_BIT = 6;
  localparam int G_CLKOUT_BIT = 7;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [7:0] pull;
  } pin_drive_t;

  typedef struct packed {
    logic halt_request;
    logic idle_request;
    logic alt_sk_phase;
    logic halt_restart_delay_enable;
  } special_ctrl_t;

  typedef struct packed {
    logic external_interrupt_pin;
    logic timer1_capture_pin;
    logic timer1_io_pin;
    logic serial_data_out;
    logic serial_shift_clock;
    logic serial_data_in;
  } port_g_alt_t;

  typedef struct packed {
    logic timer3_input_pin;
    logic timer3_io_pin;
    logic timer2_input_pin;
    logic timer2_io_pin;
    logic usart_receive_pin;
    logic usart_transmit_pin;
    logic usart_clock_pin;
    logic low_speed_osc_in;
  } port_l_alt_t;
endpackage

//--- gpio_ports.sv
// General purpose port block with special port G controls and output-only port D
`timescale 1ns/100ps
// Function
// - Config and latch bit per pin: 00 hi-Z, 01 pull-up, 10 drive 0, 11 drive 1.
// - Each bidirectional port has config, latch and read-only pin sense registers.
// - Six 8-bit ports plus 4-bit port F, every bit independent.
// - Port G latch bits 6 and 7 read back as zero.
// - Writing one to port G latch bit 7 requests halt.
// - Writing one to port G latch bit 6 requests idle.
// - Port G config bit 6 selects alternate serial shift clock phase.
// - Port G config bit 7 enables restart delay only with RC clock.
// - Port G pin 6 is always hi-Z input; pin 7 is oscillator clock output.
// - Watchdog option makes G1 the watchdog output with pull-up, ignoring bits.
// - Without watchdog option G1 is an ordinary configurable bit.
// - Port G alternates: interrupt, timer 1 capture and I/O, serial pins.
// - All port L pins feed the multi-input wake-up logic.
// - Port L alternates: timers 2 and 3, USART pins, low-speed oscillator.
// - Port D is output only and forced high during reset.
module gpio_ports (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Bidirectional pins, ports A,B,C,E,F,G,L
  input wire logic [gpio_pkg::NUM_PORTS*8-1:0] pins_in,
  output logic [gpio_pkg::NUM_PORTS*8-1:0] pins_out,
  output logic [gpio_pkg::NUM_PORTS*8-1:0] pins_oe,
  output logic [gpio_pkg::NUM_PORTS*8-1:0] pins_pull,
  // Output-only port D
  output logic [7:0] port_d_out,
  // Option and clock sources
  input wire logic watchdog_option,
  input wire logic rc_clock_option,
  input wire logic watchdog_fault_output_src,
  input wire logic oscillator_clock_src,
  // Special controls
  output gpio_pkg::special_ctrl_t special_ctrl,
  output logic [7:0] wakeup_sense,
  output gpio_pkg::port_g_alt_t port_g_alt,
  output gpio_pkg::port_l_alt_t port_l_alt
);
  import gpio_pkg::*;

  logic [7:0] port_direction_config_r [NUM_PORTS];
  logic [7:0] port_output_latch_r [NUM_PORTS];
  logic [7:0] port_pin_sense [NUM_PORTS];
  logic [7:0] port_d_r;
  logic halt_req_r;
  logic idle_req_r;
  logic ack_r;
  logic [31:0] rdata_nxt;
  logic [NUM_PORTS*8-1:0] cell_out;
  logic [NUM_PORTS*8-1:0] cell_oe;
  logic [NUM_PORTS*8-1:0] cell_pull;
  logic [NUM_PORTS*8-1:0] cell_sense;
  logic [2:0] acc_port;
  logic [1:0] acc_reg;
  logic acc_bidir;
  logic wr_go;
  logic g_latch_wr;

  // Width mask per port
  function automatic logic [7:0] port_mask(input logic [2:0] p);
    port_mask = (p == PORT_F) ? PORT_F_MASK : 8'hFF;
  endfunction

  // Register select on a bidirectional port
  function automatic logic reg_hit(input logic [7:0] addr, input logic [2:0] p,
                                   input logic [1:0] r);
    reg_hit = !addr[7] && addr[6:4] == p && addr[3:2] == r;
  endfunction

  assign acc_port = avs_address[6:4];
  assign acc_reg = avs_address[3:2];
  assign acc_bidir = ~avs_address[7] && (acc_port < 3'(NUM_PORTS));
  assign wr_go = avs_write && ack_r;
  assign g_latch_wr = wr_go && avs_byteenable[0] && reg_hit(avs_address, PORT_G, REG_LATCH);

  // One wait state per access
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end

  // Waitrequest from a flop, low for the cycle after a request is seen
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
    end
  end

  // Config and latch registers
  generate
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          port_direction_config_r[p] <= CONFIG_RESET;
        end else if (wr_go && avs_byteenable[0]
                     && reg_hit(avs_address, 3'(p), REG_CONFIG)) begin
          port_direction_config_r[p] <= avs_writedata[7:0] & port_mask(3'(p));
        end
      end
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          port_output_latch_r[p] <= LATCH_RESET;
        end else if (wr_go && avs_byteenable[0]
                     && reg_hit(avs_address, 3'(p), REG_LATCH)) begin
          port_output_latch_r[p] <= avs_writedata[7:0] & port_mask(3'(p));
        end
      end
      for (genvar b = 0; b < 8; b++) begin : g_bit
        gpio_bit_cell u_cell (
          .mclk(mclk),
          .rst(rst),
          .cfg(port_direction_config_r[p][b]),
          .dat(port_output_latch_r[p][b]),
          .pin_in(pins_in[p*8+b]),
          .pin_out(cell_out[p*8+b]),
          .pin_oe(cell_oe[p*8+b]),
          .pin_pull(cell_pull[p*8+b]),
          .sense(cell_sense[p*8+b])
        );
      end
      assign port_pin_sense[p] = cell_sense[p*8 +: 8] & port_mask(3'(p));
    end
  endgenerate

  // Halt request follows port G latch bit 7, cleared on write of zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      halt_req_r <= 1'b0;
    end else if (g_latch_wr) begin
      halt_req_r <= avs_writedata[G_HALT_BIT];
    end
  end

  // Idle request follows port G latch bit 6, cleared on write of zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      idle_req_r <= 1'b0;
    end else if (g_latch_wr) begin
      idle_req_r <= avs_writedata[G_IDLE_BIT];
    end
  end

  // Port D register, preset high in reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      port_d_r <= PORT_D_RESET;
    end else if (wr_go && avs_address == ADDR_PORT_D && avs_byteenable[0]) begin
      port_d_r <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      port_d_out <= PORT_D_RESET;
    end else begin
      port_d_out <= port_d_r;
    end
  end

  // Read mux
  always_comb begin
    rdata_nxt = UNMAPPED_DATA;
    if (acc_bidir) begin
      case (acc_reg)
        REG_CONFIG: rdata_nxt = {24'h000000, port_direction_config_r[acc_port]};
        REG_LATCH: begin
          rdata_nxt = {24'h000000, port_output_latch_r[acc_port]};
          if (acc_port == PORT_G) begin
            rdata_nxt[G_HALT_BIT] = 1'b0;
            rdata_nxt[G_IDLE_BIT] = 1'b0;
          end
        end
        REG_SENSE: rdata_nxt = {24'h000000, port_pin_sense[acc_port]};
        default: rdata_nxt = UNMAPPED_DATA;
      endcase
    end else if (avs_address == ADDR_PORT_D) begin
      rdata_nxt = {24'h000000, port_d_r};
    end else if (avs_address == ADDR_STATUS) begin
      rdata_nxt = {28'h0000000, special_ctrl};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_readdata <= UNMAPPED_DATA;
    end else if (avs_read && !ack_r) begin
      avs_readdata <= rdata_nxt;
    end
  end

  // Pin drive values, G7 carries the oscillator clock
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pins_out <= '0;
    end else begin
      pins_out <= cell_out;
      pins_out[PORT_G*8+G_CLKOUT_BIT] <= oscillator_clock_src;
      if (watchdog_option) begin
        pins_out[PORT_G*8+G_WATCHDOG_BIT] <= 1'b0;
      end
    end
  end

  // Drive enables, G6 never driven, G7 driven whenever out of reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pins_oe <= '0;
    end else begin
      pins_oe <= cell_oe;
      pins_oe[PORT_G*8+G_INPUT_ONLY_BIT] <= 1'b0;
      pins_oe[PORT_G*8+G_CLKOUT_BIT] <= 1'b1;
      if (watchdog_option) begin
        // Open low drive, weak pull-up on whether driving or not; G1 config and latch ignored
        pins_oe[PORT_G*8+G_WATCHDOG_BIT] <= ~watchdog_fault_output_src;
      end
      // Otherwise G1 keeps the cell decode
    end
  end

  // Weak pull-ups, none on the dedicated G6 and G7 pins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pins_pull <= '0;
    end else begin
      pins_pull <= cell_pull;
      pins_pull[PORT_G*8+G_INPUT_ONLY_BIT] <= 1'b0;
      pins_pull[PORT_G*8+G_CLKOUT_BIT] <= 1'b0;
      if (watchdog_option) begin
        pins_pull[PORT_G*8+G_WATCHDOG_BIT] <= 1'b1;
      end
    end
  end

  // Special control outputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      special_ctrl <= '0;
    end else begin
      special_ctrl.halt_request <= halt_req_r;
      special_ctrl.idle_request <= idle_req_r;
      special_ctrl.alt_sk_phase <= port_direction_config_r[PORT_G][G_ALT_SK_BIT];
      special_ctrl.halt_restart_delay_enable <=
        port_direction_config_r[PORT_G][G_DELAY_BIT] & rc_clock_option;
    end
  end

  // Wake-up sources, all port L pins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wakeup_sense <= '0;
    end else begin
      wakeup_sense <= port_pin_sense[PORT_L];
    end
  end

  // Port L alternate function taps
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      port_l_alt <= '0;
    end else begin
      port_l_alt <= port_pin_sense[PORT_L];
    end
  end

  // Port G alternate function taps
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      port_g_alt <= '0;
    end else begin
      port_g_alt.external_interrupt_pin <= port_pin_sense[PORT_G][0];
      port_g_alt.timer1_capture_pin <= port_pin_sense[PORT_G][2];
      port_g_alt.timer1_io_pin <= port_pin_sense[PORT_G][3];
      port_g_alt.serial_data_out <= port_pin_sense[PORT_G][4];
      port_g_alt.serial_shift_clock <= port_pin_sense[PORT_G][5];
      port_g_alt.serial_data_in <= port_pin_sense[PORT_G][6];
    end
  end
endmodule

//--- gpio_ports_assertions.sv
// Checker on the port block top level
`timescale 1ns/100ps
module gpio_ports_assertions (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Pins and options
  input wire logic [55:0] pins_in,
  input wire logic [55:0] pins_out,
  input wire logic [55:0] pins_oe,
  input wire logic [55:0] pins_pull,
  input wire logic [7:0] port_d_out,
  input wire logic [7:0] wakeup_sense,
  input wire logic watchdog_option,
  input wire logic oscillator_clock_src
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_D_RESET: assert property (disable iff (1'b0) rst |-> port_d_out == 8'hFF)
    else $error("port D not high in reset");
  AST_ONE_WAIT: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  AST_ANSWER: assert property ($rose(avs_read) |-> ##[1:2] !avs_waitrequest)
    else $error("read not answered");
  AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address == 8'h7C
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_G_LATCH: assert property (avs_read && !avs_waitrequest && avs_address == 8'h54
    |-> avs_readdata[7:6] == 2'h0)
    else $error("port G latch top bits not zero");
  AST_F_UPPER: assert property (pins_oe[39:36] == 4'h0 && pins_pull[39:36] == 4'h0)
    else $error("port F upper bits active");
  AST_EXCL: assert property ((pins_oe & pins_pull & ~(56'h1 << 41)) == 56'h0)
    else $error("pull and drive together");
  AST_G6_IN: assert property (!pins_oe[46])
    else $error("G6 driven");
  AST_G7_CLK: assert property (!$past(rst) |-> pins_oe[47]
    && pins_out[47] == $past(oscillator_clock_src))
    else $error("G7 not clock output");
  AST_WD_PULL: assert property (watchdog_option[*3] |-> pins_pull[41])
    else $error("watchdog pin not pulled up");
  AST_WAKE: assert property ($stable(pins_in[55:48])[*5] ##0 !$past(rst, 6)
    |-> wakeup_sense == pins_in[55:48])
    else $error("wake-up sense wrong");
  COV_WR: cover property (avs_write && !avs_waitrequest);
  COV_UNMAP: cover property (avs_read && !avs_waitrequest && avs_address == 8'h7C);
  COV_WD: cover property (watchdog_option[*3]);
endmodule
bind gpio_ports gpio_ports_assertions u_gpio_ports_assertions (.mclk(mclk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pins_in(pins_in),
  .pins_out(pins_out), .pins_oe(pins_oe), .pins_pull(pins_pull), .port_d_out(port_d_out),
  .wakeup_sense(wakeup_sense), .watchdog_option(watchdog_option),
  .oscillator_clock_src(oscillator_clock_src));

//--- tb_top.sv
// Testbench for the port block
`timescale 1ns/100ps
module tb_top;
  import gpio_pkg::*;
  logic mclk, rst, avs_read, avs_write, avs_waitrequest, wd_opt, rc_opt, wd_src, osc;
  logic [7:0] avs_address, port_d_out, wakeup_sense, rd_v, m;
  logic [31:0] avs_writedata, avs_readdata;
  logic [55:0] pins_in, pins_out, pins_oe, pins_pull, ext, ext_en;
  special_ctrl_t special_ctrl;
  port_g_alt_t port_g_alt;
  port_l_alt_t port_l_alt;
  int n_fail, n_tests;
  gpio_ports u_gpio_ports (.mclk(mclk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pins_in(pins_in), .pins_out(pins_out), .pins_oe(pins_oe), .pins_pull(pins_pull),
    .port_d_out(port_d_out), .watchdog_option(wd_opt), .rc_clock_option(rc_opt),
    .watchdog_fault_output_src(wd_src), .oscillator_clock_src(osc),
    .special_ctrl(special_ctrl), .wakeup_sense(wakeup_sense), .port_g_alt(port_g_alt),
    .port_l_alt(port_l_alt));
  gpio_board_model u_gpio_board_model (.mclk(mclk), .pins_out(pins_out), .pins_oe(pins_oe),
    .pins_pull(pins_pull), .ext(ext), .ext_en(ext_en), .pins_in(pins_in));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      osc <= 1'b0;
    end else begin
      osc <= ~osc;
    end
  end
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= 1'b1;
    @(posedge mclk iff avs_waitrequest === 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge mclk iff avs_waitrequest === 1'b0);
    d = avs_readdata[7:0];
    avs_read <= 1'b0;
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    finish_test();
  end
  initial begin
    {rst, wd_opt, wd_src, rc_opt} <= 4'b1011;
    {avs_read, avs_write, avs_address, avs_writedata} <= '0;
    ext = 56'h96A53C5AC369F0;
    ext_en = '1;
    repeat (4) @(posedge mclk);
    chk("d_reset", port_d_out, 8'hFF);
    rst <= 1'b0;
    for (int p = 0; p < 7; p++) begin
      m = (p == 4) ? 8'h0F : (p == 5) ? 8'h3F : 8'hFF;
      rd({p[3:0], 4'h0}, rd_v);
      chk("cfg_reset", rd_v, 8'h00);
      wr({p[3:0], 4'h0}, 8'hF0);
      wr({p[3:0], 4'h4}, 8'hCC);
      wr({p[3:0], 4'h8}, 8'hFF);
      repeat (4) @(posedge mclk);
      chk("oe", pins_oe[p*8+:8] & m, 8'hF0 & m);
      chk("out", pins_out[p*8+:8] & m, 8'hC0 & m);
      chk("pull", pins_pull[p*8+:8] & m, 8'h0C & m);
      rd({p[3:0], 4'h0}, rd_v);
      chk("cfg", rd_v & m, 8'hF0 & m);
      rd({p[3:0], 4'h4}, rd_v);
      chk("latch", rd_v, 8'hCC & m);
      rd({p[3:0], 4'h8}, rd_v);
      chk("sense", rd_v & m, (8'hC0 | ext[p*8+:8] & 8'h0F) & m);
    end
    $display("test modes done");
    chk("special", {4'h0, special_ctrl}, 8'h0F);
    rc_opt <= 1'b0;
    wr(8'h54, 8'h00);
    repeat (3) @(posedge mclk);
    chk("special_off", {4'h0, special_ctrl}, 8'h02);
    rd(ADDR_STATUS, rd_v);
    chk("status", rd_v, 8'h02);
    chk("wake", wakeup_sense, 8'hC6);
    chk("l_alt", port_l_alt, 8'hC6);
    chk("g_alt", {2'h0, port_g_alt}, 8'h30);
    $display("test special done");
    wd_opt <= 1'b1;
    wd_src <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("wd_low", {5'h0, pins_oe[41], pins_out[41], pins_pull[41]}, 8'h05);
    wd_src <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("wd_high", {5'h0, pins_oe[41], pins_pull[41]}, 8'h01);
    wd_opt <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("g1_gpio", {6'h0, pins_oe[41], pins_pull[41]}, 8'h00);
    wr(8'h50, 8'h02);
    repeat (4) @(posedge mclk);
    chk("g1_cfg", {7'h0, pins_oe[41]}, 8'h01);
    wr(ADDR_PORT_D, 8'h3C);
    wr(8'h7C, 8'hFF);
    rd(8'h7C, rd_v);
    chk("unmapped", rd_v, 8'h00);
    repeat (3) @(posedge mclk);
    chk("d_out", port_d_out, 8'h3C);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("d_rst2", port_d_out, 8'hFF);
    chk("oe_rst2", pins_oe[7:0], 8'h00);
    rst <= 1'b0;
    $display("test pins done");
    finish_test();
  end
endmodule
